//--- pkg/pfc_regs.vh
// Overview of operation
// - Trigger mode bits 23:21: rising, falling, both edges, high level, low level.
// - With enable bit 20 clear, a trigger sets no pending flag and no interrupt request is raised.
// - With enable bit 20 set, a detected trigger sets the pending flag.
// - Request reaches interrupt controller only when bits 20 and 25 are both one.
// - Bit 4 picks digital multiplexed function at zero, analog path at one.
// - Bits 3:0 select one of ten functions; reset value 0x1 is plain I/O.
// - Bits 14:12 give eight drive levels, 2mA to 16mA; reset 001.
// - Bit 9 enables the weak pull-down.
// - Bit 8 enables the weak pull-up, bit 11 the strong pull-up.
// - Bit 5 switches the Schmitt input; resets to zero.
`ifndef PFC_REGS_VH
`define PFC_REGS_VH

`define PFC_ADDR_W 8
`define PFC_CTRL_OFS 8'h20
`define PFC_STAT_OFS 8'h40
`define PFC_CTRL_RST 32'h00001001
`define PFC_DRV_RST 3'h1
`define PFC_CTRL_WMASK 32'h02FFFBFF
`define PFC_STAT_WMASK 32'h00000001

`define PFC_FWD_BIT 25
`define PFC_TRIG_HI 23
`define PFC_TRIG_LO 21
`define PFC_EN_BIT 20
`define PFC_DRV_HI 14
`define PFC_DRV_LO 12
`define PFC_SPU_BIT 11
`define PFC_WPD_BIT 9
`define PFC_WPU_BIT 8
`define PFC_IE_BIT 7
`define PFC_OE_BIT 6
`define PFC_SMT_BIT 5
`define PFC_ANA_BIT 4
`define PFC_FUNC_HI 3
`define PFC_FUNC_LO 0
`define PFC_PEND_BIT 0

`define PFC_TRIG_RISE 3'h0
`define PFC_TRIG_FALL 3'h1
`define PFC_TRIG_BOTH 3'h2
`define PFC_TRIG_HIGH 3'h3
`define PFC_TRIG_LOW 3'h4

`define PFC_NUM_FUNC 10
`define PFC_FUNC_IO 4'h1

`endif

//--- logic/pfc_trig_detect.v
`timescale 1ns/1ps
`default_nettype none
`include "pfc_regs.vh"

module pfc_trig_detect
(
	input wire clock,
	input wire arst_n,
	input wire pin_level,
	input wire [2:0] trigger_mode_select,
	output reg trig_event
);

	reg prev_q;
	wire rise;
	wire fall;

	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			prev_q <= 1'b0;
		else
			prev_q <= pin_level;
	end

	assign rise = pin_level & ~prev_q;
	assign fall = ~pin_level & prev_q;

	// Reserved mode codes never produce an event.
	always @*
	begin
		case (trigger_mode_select)
			`PFC_TRIG_RISE: trig_event = rise;
			`PFC_TRIG_FALL: trig_event = fall;
			`PFC_TRIG_BOTH: trig_event = rise | fall;
			`PFC_TRIG_HIGH: trig_event = pin_level;
			`PFC_TRIG_LOW: trig_event = ~pin_level;
			default: trig_event = 1'b0;
		endcase
	end

endmodule
`default_nettype wire

//--- logic/pfc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "pfc_regs.vh"

module pfc_top
#(
	parameter NUM_FUNC = `PFC_NUM_FUNC
)
(
	input wire clock,
	input wire arst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`PFC_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_q,
	output reg pready_q,
	output reg pslverr_q,
	input wire pad_in,
	input wire [NUM_FUNC-1:0] func_out,
	input wire [NUM_FUNC-1:0] func_oe,
	output reg pad_out_q,
	output reg pad_oe_q,
	output reg pad_input_enable_q,
	output reg schmitt_input_enable_q,
	output reg weak_pullup_enable_q,
	output reg weak_pulldown_enable_q,
	output reg strong_pullup_enable_q,
	output reg [2:0] drive_strength_level_q,
	output reg analog_connect_q,
	output reg [NUM_FUNC-1:0] func_active_q,
	output reg [NUM_FUNC-1:0] func_in_q,
	output reg irq_pending_q,
	output reg interrupt_controller_req_q
);

	reg [31:0] pin_five_control_q;
	reg [31:0] pin_five_control_d;
	reg pending_d;
	reg [31:0] rdata_d;
	reg hit_ctrl;
	reg hit_stat;
	wire [NUM_FUNC-1:0] active_d;
	reg pad_out_d;
	reg pad_oe_d;

	wire setup_ph;
	wire access_done;
	wire wr_ctrl;
	wire wr_stat;
	wire trig_event;
	wire irq_pending_enable;
	wire irq_forward_allow;
	wire digital_path;
	wire [3:0] pin_function_select;

	assign setup_ph = psel & ~penable;
	assign access_done = psel & penable & pready_q;
	assign wr_ctrl = access_done & pwrite & hit_ctrl;
	assign wr_stat = access_done & pwrite & hit_stat;

	assign irq_pending_enable = pin_five_control_q[`PFC_EN_BIT];
	assign irq_forward_allow = pin_five_control_q[`PFC_FWD_BIT];
	assign digital_path = ~pin_five_control_q[`PFC_ANA_BIT];
	assign pin_function_select = pin_five_control_q[`PFC_FUNC_HI:`PFC_FUNC_LO];

	pfc_trig_detect u_trig
	(
		.clock(clock),
		.arst_n(arst_n),
		.pin_level(pad_in),
		.trigger_mode_select(pin_five_control_q[`PFC_TRIG_HI:`PFC_TRIG_LO]),
		.trig_event(trig_event)
	);

	// Address decode and read data for the two registers.
	always @*
	begin
		hit_ctrl = (paddr == `PFC_CTRL_OFS);
		hit_stat = (paddr == `PFC_STAT_OFS);
		rdata_d = 32'h00000000;
		if (hit_ctrl)
			rdata_d = pin_five_control_q & `PFC_CTRL_WMASK;
		else if (hit_stat)
			rdata_d = {31'h00000000, irq_pending_q};
	end

	// Write path; reserved bits keep their zero value.
	always @*
	begin
		pin_five_control_d = pin_five_control_q;
		if (wr_ctrl)
			pin_five_control_d = pwdata & `PFC_CTRL_WMASK;
	end

	// Pending flag: a trigger in the clearing cycle wins over the clear.
	always @*
	begin
		pending_d = irq_pending_q;
		if (wr_stat && pwdata[`PFC_PEND_BIT])
			pending_d = 1'b0;
		if (irq_pending_enable && trig_event)
			pending_d = 1'b1;
	end

	// One-hot function selection; reserved codes select nothing.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_FUNC; gi = gi + 1)
		begin : g_func
			localparam [3:0] FUNC_CODE = gi;
			assign active_d[gi] = digital_path && (pin_function_select == FUNC_CODE);
		end
	endgenerate

	always @*
	begin
		pad_out_d = |(func_out & active_d);
		pad_oe_d = pin_five_control_q[`PFC_OE_BIT] & |(func_oe & active_d);
	end

	// APB slave: answers in the first access cycle, errors on unmapped addresses.
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end
		else
		begin
			pready_q <= setup_ph;
			if (setup_ph)
			begin
				pslverr_q <= ~(hit_ctrl | hit_stat);
				prdata_q <= pwrite ? 32'h00000000 : rdata_d;
			end
			else
			begin
				pslverr_q <= 1'b0;
				prdata_q <= 32'h00000000;
			end
		end
	end

	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pin_five_control_q <= `PFC_CTRL_RST;
			irq_pending_q <= 1'b0;
			interrupt_controller_req_q <= 1'b0;
		end
		else
		begin
			pin_five_control_q <= pin_five_control_d;
			irq_pending_q <= pending_d;
			interrupt_controller_req_q <= pending_d & irq_pending_enable & irq_forward_allow;
		end
	end

	// Pad controls follow the control register one cycle later.
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pad_input_enable_q <= 1'b0;
			schmitt_input_enable_q <= 1'b0;
			weak_pullup_enable_q <= 1'b0;
			weak_pulldown_enable_q <= 1'b0;
			strong_pullup_enable_q <= 1'b0;
			drive_strength_level_q <= `PFC_DRV_RST;
			analog_connect_q <= 1'b0;
			func_active_q <= {NUM_FUNC{1'b0}};
			func_in_q <= {NUM_FUNC{1'b0}};
			pad_out_q <= 1'b0;
			pad_oe_q <= 1'b0;
		end
		else
		begin
			pad_input_enable_q <= pin_five_control_q[`PFC_IE_BIT];
			schmitt_input_enable_q <= pin_five_control_q[`PFC_SMT_BIT];
			weak_pullup_enable_q <= pin_five_control_q[`PFC_WPU_BIT];
			weak_pulldown_enable_q <= pin_five_control_q[`PFC_WPD_BIT];
			strong_pullup_enable_q <= pin_five_control_q[`PFC_SPU_BIT];
			drive_strength_level_q <= pin_five_control_q[`PFC_DRV_HI:`PFC_DRV_LO];
			analog_connect_q <= pin_five_control_q[`PFC_ANA_BIT];
			func_active_q <= active_d;
			func_in_q <= pin_five_control_q[`PFC_IE_BIT] ? (active_d & {NUM_FUNC{pad_in}}) :
				{NUM_FUNC{1'b0}};
			pad_out_q <= pad_out_d;
			pad_oe_q <= pad_oe_d;
		end
	end

endmodule
`default_nettype wire

//--- dv/pfc_periph.sv
`timescale 1ns/1ps
`default_nettype none
module pfc_periph (
	input wire logic clock,
	input wire logic [9:0] func_active_q,
	output logic [9:0] func_out,
	output logic [9:0] func_oe
);
	logic t_q = 1'b0;
	always @(posedge clock) t_q <= ~t_q;
	assign func_out = {10{t_q}} ^ 10'h2AA;
	assign func_oe = func_active_q;
endmodule
`default_nettype wire

//--- dv/pfc_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pfc_top_monitor (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata_q,
	input wire logic pready_q,
	input wire logic pslverr_q,
	input wire logic irq_pending_q,
	input wire logic interrupt_controller_req_q,
	input wire logic [2:0] drive_strength_level_q
);
	logic [31:0] c_q;
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// Shadow of the control register, kept from completed writes.
	always @(posedge clock or negedge arst_n)
		if (!arst_n)
			c_q <= 32'h00001001;
		else if (psel && penable && pready_q && pwrite && paddr == 8'h20)
			c_q <= pwdata & 32'h02FFFBFF;
	a_ready_answer:
		assert property (psel && !penable |=> pready_q) else $error("late ready");
	a_ready_pulse:
		assert property (pready_q |=> !pready_q) else $error("ready too long");
	a_err_unmapped:
		assert property (pready_q && paddr != 8'h20 && paddr != 8'h40 |-> pslverr_q
			&& prdata_q == 0) else $error("unmapped answer");
	a_ctrl_read:
		assert property (pready_q && !pwrite && paddr == 8'h20 |-> prdata_q == c_q)
			else $error("bad read");
	a_pend_needs_en:
		assert property ($rose(irq_pending_q) |-> $past(c_q[20])) else $error("pend off");
	a_req_needs_pend:
		assert property (interrupt_controller_req_q |-> irq_pending_q) else $error("req");
	a_req_forward:
		assert property (interrupt_controller_req_q |-> $past(c_q[20]) && $past(c_q[25]))
			else $error("req masked");
	a_drive_follow:
		assert property (drive_strength_level_q == $past(c_q[14:12])) else $error("drive");
endmodule
bind pfc_top pfc_top_monitor u_mon (.clock(clock), .arst_n(arst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
	.irq_pending_q(irq_pending_q), .interrupt_controller_req_q(interrupt_controller_req_q),
	.drive_strength_level_q(drive_strength_level_q));
`default_nettype wire

//--- dv/pin_five_control_register_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pin_five_control_register_bench;
	logic clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pad_in = 0, er;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	wire [31:0] prdata_q;
	wire pready_q, pslverr_q, irq_pending_q, interrupt_controller_req_q;
	wire [9:0] func_out, func_oe, func_active_q;
	wire [2:0] drive_strength_level_q;
	wire pad_out_q, pad_oe_q, pad_input_enable_q, schmitt_input_enable_q, weak_pullup_enable_q;
	wire weak_pulldown_enable_q, strong_pullup_enable_q, analog_connect_q;
	wire [9:0] func_in_q;
	wire [5:0] pc = {analog_connect_q, strong_pullup_enable_q, weak_pulldown_enable_q,
		weak_pullup_enable_q, schmitt_input_enable_q, pad_input_enable_q};
	// Function data as the design sampled it one edge ago, for the pad output check.
	logic [9:0] fo_q = 10'h000;
	always @(posedge clock) fo_q <= func_out;
	wire [1:0] pr = {irq_pending_q, interrupt_controller_req_q};
	int mismatches = 0, cmp_count = 0, cyc = 0;
	always #50 clock = ~clock;
	pfc_periph u_per (.clock(clock), .func_active_q(func_active_q), .func_out(func_out),
		.func_oe(func_oe));
	pfc_top uut (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
		.pready_q(pready_q), .pslverr_q(pslverr_q), .pad_in(pad_in), .func_out(func_out),
		.func_oe(func_oe), .pad_out_q(pad_out_q), .pad_oe_q(pad_oe_q),
		.pad_input_enable_q(pad_input_enable_q), .schmitt_input_enable_q(schmitt_input_enable_q),
		.weak_pullup_enable_q(weak_pullup_enable_q),
		.weak_pulldown_enable_q(weak_pulldown_enable_q),
		.strong_pullup_enable_q(strong_pullup_enable_q),
		.drive_strength_level_q(drive_strength_level_q), .analog_connect_q(analog_connect_q),
		.func_active_q(func_active_q), .func_in_q(func_in_q), .irq_pending_q(irq_pending_q),
		.interrupt_controller_req_q(interrupt_controller_req_q));
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("FAIL t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready_q !== 1'b1);
		rd = prdata_q;
		er = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic t_regs;
		apb(0, 8'h20, 0);
		chk(32'h00001001, rd);
		chk(32'h1, {29'h0, drive_strength_level_q});
		chk(32'h0, {26'h0, pc});
		apb(1, 8'h20, 32'hFFFFFFFF);
		apb(0, 8'h20, 0);
		chk(32'h02FFFBFF, rd);
		chk(32'h7, {29'h0, drive_strength_level_q});
		apb(0, 8'h80, 0);
		chk(32'h0, rd);
		chk(32'h1, {31'h0, er});
		$display("register test done");
	endtask
	task automatic pad_case(input logic [31:0] v, input logic [5:0] epc,
		input logic [9:0] efa, input logic eoe, input logic [9:0] efi);
		apb(1, 8'h20, v);
		repeat (2) @(posedge clock);
		chk({26'h0, epc}, {26'h0, pc});
		chk({22'h0, efa}, {22'h0, func_active_q});
		chk({31'h0, eoe}, {31'h0, pad_oe_q});
		chk({31'h0, |(fo_q & efa)}, {31'h0, pad_out_q});
		chk({22'h0, efi}, {22'h0, func_in_q});
	endtask
	task automatic t_pad;
		pad_in <= 1'b1;
		pad_case(32'h00005BE3, 6'h1F, 10'h008, 1'b1, 10'h008);
		chk(32'h5, {29'h0, drive_strength_level_q});
		pad_case(32'h00000310, 6'h2C, 10'h000, 1'b0, 10'h000);
		pad_case(32'h00000889, 6'h11, 10'h200, 1'b0, 10'h200);
		pad_case(32'h0000004A, 6'h00, 10'h000, 1'b0, 10'h000);
		pad_case(32'h00000000, 6'h00, 10'h001, 1'b0, 10'h000);
		$display("pad test done");
	endtask
	task automatic t_trig;
		for (int m = 0; m < 5; m++)
		begin
			pad_in <= (m == 1 || m == 4);
			apb(1, 8'h20, {6'h0, 2'h2, m[2:0], 1'b1, 20'h01001});
			apb(1, 8'h40, 32'h1);
			chk(32'h0, {30'h0, pr});
			pad_in <= !(m == 1 || m == 4);
			repeat (3) @(posedge clock);
			chk(32'h3, {30'h0, pr});
		end
		$display("trigger test done");
	endtask
	task automatic t_gate;
		pad_in <= 1'b0;
		apb(1, 8'h20, 32'h02001001);
		apb(1, 8'h40, 32'h1);
		pad_in <= 1'b1;
		repeat (3) @(posedge clock);
		chk(32'h0, {30'h0, pr});
		pad_in <= 1'b0;
		apb(1, 8'h20, 32'h00101001);
		pad_in <= 1'b1;
		repeat (3) @(posedge clock);
		chk(32'h2, {30'h0, pr});
		$display("gating test done");
	endtask
	task automatic complete_run;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			mismatches++;
			complete_run;
		end
	end
	initial
	begin
		repeat (4) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		t_regs;
		t_trig;
		t_gate;
		t_pad;
		complete_run;
	end
endmodule
`default_nettype wire
